// ===== hw/lsmdc_pkg.sv
/*
  Constants and types for the line sensor mode and direction control block.
  Assumes a single 250 MHz clock domain and a decoded command stream from a
  serial command parser outside this block.
*/
package lsmdc_pkg;

  // Sensitivity readout modes
  typedef enum logic [1:0] {
    LSMDC_MODE_HIGH = 2'b00,
    LSMDC_MODE_LOW  = 2'b01,
    LSMDC_MODE_TALL = 2'b10
  } lsmdc_mode_t;

  // Decoded serial commands
  typedef enum logic [1:0] {
    LSMDC_CMD_MODE    = 2'b00,
    LSMDC_CMD_DIR_SRC = 2'b01,
    LSMDC_CMD_DIR_SW  = 2'b10
  } lsmdc_cmd_t;

  // Direction source selection values
  localparam logic LSMDC_SRC_SW  = 1'b0;
  localparam logic LSMDC_SRC_CC3 = 1'b1;

  // Direction values
  localparam logic LSMDC_DIR_FWD = 1'b0;
  localparam logic LSMDC_DIR_REV = 1'b1;

  // Reset values
  localparam lsmdc_mode_t LSMDC_RST_MODE    = LSMDC_MODE_HIGH;
  localparam logic        LSMDC_RST_DIR_SRC = LSMDC_SRC_SW;
  localparam logic        LSMDC_RST_DIR_SW  = LSMDC_DIR_FWD;

  // Synchroniser depth for the direction pin
  localparam int LSMDC_SYNC_STAGES = 2;

endpackage : lsmdc_pkg

// ===== hw/lsmdc_sync_if.sv
/*
  Carrier between the control block and its direction pin synchroniser.
  Assumes both ends sit in the same clock domain.
*/
`timescale 1ns/10ps
interface lsmdc_sync_if;
  logic raw;
  logic synced;

  modport ctrl (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : lsmdc_sync_if

// ===== hw/lsmdc_sync.sv
/*
  Two stage synchroniser for the frame grabber direction input.
  Assumes the input is asynchronous to i_clock.
*/
`timescale 1ns/10ps
module lsmdc_sync
  import lsmdc_pkg::*;
(
  input  wire logic  i_clock,
  input  wire logic  i_rst,
  lsmdc_sync_if.sync bus
);

  logic [LSMDC_SYNC_STAGES-1:0] stage;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      stage <= '0;
    end else begin
      stage <= {stage[LSMDC_SYNC_STAGES-2:0], bus.raw};
    end
  end

  assign bus.synced = stage[LSMDC_SYNC_STAGES-1];

endmodule : lsmdc_sync

// ===== hw/lsmdc_ctrl.sv
/*
  Sensitivity mode and charge shift direction control for a dual line imager.
  Assumes a decoded command strobe from the serial parser and a one cycle
  line boundary pulse from the line timing generator.

// Overview of operation
// - High mode sums both lines, same line
// - Low mode reads bottom line only
// - Tall mode merges lines, double height
// - Mode changes only by serial command
// - High mode allows forward or reverse shift
// - Direction source software or CC3 input
*/
`timescale 1ns/10ps
module lsmdc_ctrl
  import lsmdc_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic              i_cmd_valid,
  input  wire lsmdc_pkg::lsmdc_cmd_t i_cmd,
  input  wire logic [1:0]        i_cmd_arg,
  input  wire logic              i_cc3,
  input  wire logic              i_line_start,
  output lsmdc_pkg::lsmdc_mode_t o_mode,
  output logic                   o_read_bottom,
  output logic                   o_read_top,
  output logic                   o_sum_lines,
  output logic                   o_tall_pixel,
  output logic                   o_dir_reverse,
  output logic                   o_cmd_reject
);
  import lsmdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Direction pin synchroniser

  lsmdc_sync_if sync_bus ();

  assign sync_bus.raw = i_cc3;

  lsmdc_sync u_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .bus     (sync_bus.sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  function automatic logic mode_arg_ok(input logic [1:0] arg);
    mode_arg_ok = (arg == LSMDC_MODE_HIGH) || (arg == LSMDC_MODE_LOW) ||
                  (arg == LSMDC_MODE_TALL);
  endfunction : mode_arg_ok

  lsmdc_mode_t pend_mode;
  logic        pend_dir_src;
  logic        pend_dir_sw;

  wire logic   cmd_mode    = i_cmd_valid && (i_cmd == LSMDC_CMD_MODE);
  wire logic   cmd_src     = i_cmd_valid && (i_cmd == LSMDC_CMD_DIR_SRC);
  wire logic   cmd_sw      = i_cmd_valid && (i_cmd == LSMDC_CMD_DIR_SW);
  wire logic   mode_ok     = mode_arg_ok(i_cmd_arg);
  wire logic   bad_cmd     = (cmd_mode && !mode_ok) ||
                             (i_cmd_valid && !cmd_mode && !cmd_src && !cmd_sw);

  wire lsmdc_mode_t next_pend_mode =
    (cmd_mode && mode_ok) ? lsmdc_mode_t'(i_cmd_arg) : pend_mode;
  wire logic next_pend_dir_src = cmd_src ? i_cmd_arg[0] : pend_dir_src;
  wire logic next_pend_dir_sw  = cmd_sw  ? i_cmd_arg[0] : pend_dir_sw;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pend_mode    <= LSMDC_RST_MODE;
      pend_dir_src <= LSMDC_RST_DIR_SRC;
      pend_dir_sw  <= LSMDC_RST_DIR_SW;
      o_cmd_reject <= 1'b0;
    end else begin
      pend_mode    <= next_pend_mode;
      pend_dir_src <= next_pend_dir_src;
      pend_dir_sw  <= next_pend_dir_sw;
      o_cmd_reject <= bad_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line boundary apply

  wire logic next_dir_raw =
    (pend_dir_src == LSMDC_SRC_CC3) ? sync_bus.synced : pend_dir_sw;
  wire logic next_dir =
    (pend_mode == LSMDC_MODE_HIGH) ? next_dir_raw : LSMDC_DIR_FWD;

  logic next_bottom;
  logic next_top;
  logic next_sum;
  logic next_tall;

  always_comb begin
    next_bottom = 1'b1;
    next_top    = 1'b1;
    next_sum    = 1'b0;
    next_tall   = 1'b0;
    case (pend_mode)
      LSMDC_MODE_HIGH: begin
        next_sum = 1'b1;
      end
      LSMDC_MODE_LOW: begin
        next_top = 1'b0;
      end
      LSMDC_MODE_TALL: begin
        next_tall = 1'b1;
      end
      default: begin
        next_sum = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_mode        <= LSMDC_RST_MODE;
      o_read_bottom <= 1'b1;
      o_read_top    <= 1'b1;
      o_sum_lines   <= 1'b1;
      o_tall_pixel  <= 1'b0;
      o_dir_reverse <= LSMDC_DIR_FWD;
    end else if (i_line_start) begin
      o_mode        <= pend_mode;
      o_read_bottom <= next_bottom;
      o_read_top    <= next_top;
      o_sum_lines   <= next_sum;
      o_tall_pixel  <= next_tall;
      o_dir_reverse <= next_dir;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  AST_HIGH_SUMS: assert property (
    (o_mode == LSMDC_MODE_HIGH) |-> (o_sum_lines && o_read_top && o_read_bottom && !o_tall_pixel))
    else $error("High mode not summing both lines");

  AST_LOW_BOTTOM: assert property (
    (o_mode == LSMDC_MODE_LOW) |-> (o_read_bottom && !o_read_top && !o_sum_lines))
    else $error("Low mode reads the upper line");

  AST_TALL_MERGE: assert property (
    (o_mode == LSMDC_MODE_TALL) |-> (o_tall_pixel && o_read_top && !o_sum_lines))
    else $error("Tall mode not merging lines");

  AST_MODE_CMD: assert property (
    (cmd_mode && mode_ok) |=> (pend_mode == $past(i_cmd_arg)))
    else $error("Mode command not captured");

  AST_MODE_HOLD: assert property (
    !(cmd_mode && mode_ok) |=> $stable(pend_mode))
    else $error("Pending mode changed without command");

  AST_DIR_FWD_ONLY: assert property (
    (o_mode != LSMDC_MODE_HIGH) |-> (o_dir_reverse == LSMDC_DIR_FWD))
    else $error("Reverse shift outside high mode");

  AST_DIR_CC3: assert property (
    (i_line_start && pend_mode == LSMDC_MODE_HIGH && pend_dir_src == LSMDC_SRC_CC3)
      |=> (o_dir_reverse == $past(sync_bus.synced)))
    else $error("Direction not following synchronised input");

  AST_DIR_SW: assert property (
    (i_line_start && pend_mode == LSMDC_MODE_HIGH && pend_dir_src == LSMDC_SRC_SW)
      |=> (o_dir_reverse == $past(pend_dir_sw)))
    else $error("Direction not following software setting");

  AST_CC3_LATENCY: assert property (
    $rose(i_cc3) ##1 i_cc3 [*2] |-> sync_bus.synced)
    else $error("Direction input not synchronised in two cycles");

  AST_LINE_ONLY: assert property (
    !i_line_start |=> ($stable(o_mode) && $stable(o_dir_reverse)))
    else $error("Output changed in mid line");

  AST_LINE_OTHERS: assert property (
    !i_line_start |=> ($stable(o_read_top) && $stable(o_sum_lines) && $stable(o_tall_pixel)))
    else $error("Readout control changed in mid line");

  AST_LINE_APPLY: assert property (
    i_line_start |=> (o_mode == $past(pend_mode)))
    else $error("Pending mode not applied at line start");

  AST_BOTTOM_ALWAYS: assert property (
    o_read_bottom)
    else $error("Bottom line not read");

  AST_REJECT_SET: assert property (
    bad_cmd |=> o_cmd_reject)
    else $error("Illegal command not flagged");

  AST_REJECT_CLR: assert property (
    !bad_cmd |=> !o_cmd_reject)
    else $error("Legal command flagged");

  AST_SRC_CMD: assert property (
    cmd_src |=> (pend_dir_src == $past(i_cmd_arg[0])))
    else $error("Direction source not captured");

  AST_SRC_HOLD: assert property (
    !cmd_src |=> $stable(pend_dir_src))
    else $error("Direction source changed without command");

  AST_SW_CMD: assert property (
    cmd_sw |=> (pend_dir_sw == $past(i_cmd_arg[0])))
    else $error("Software direction not captured");

  COV_TALL: cover property (i_line_start ##1 o_tall_pixel);
  COV_LOW: cover property (i_line_start ##1 (o_mode == LSMDC_MODE_LOW));
  COV_REV_CC3: cover property (
    (pend_dir_src == LSMDC_SRC_CC3) && i_line_start ##1 o_dir_reverse);
  COV_REJECT: cover property (o_cmd_reject);
  COV_REV_SW: cover property ((pend_dir_src == LSMDC_SRC_SW) && i_line_start ##1 o_dir_reverse);

endmodule : lsmdc_ctrl

// ===== verif/lsmdc_grabber.sv
/*
  Frame grabber model driving the direction pin.
  Assumes the bench sets the wanted level; the pin moves after an edge.
*/
`timescale 1ns/10ps
module lsmdc_grabber (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_level,
  output logic      o_cc3
);
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_cc3 <= 1'b0;
    end else begin
      o_cc3 <= i_level;
    end
  end
endmodule : lsmdc_grabber

// ===== verif/tb_top.sv
/*
  Self-checking bench for the mode and direction control block.
  Assumes the grabber model drives the direction pin.
*/
`timescale 1ns/10ps
module tb_top;
  import lsmdc_pkg::*;
  logic        i_clock;
  logic        i_rst;
  logic        i_cmd_valid;
  lsmdc_cmd_t  i_cmd;
  logic [1:0]  i_cmd_arg;
  logic        i_line_start;
  logic        lvl;
  logic        cc3;
  lsmdc_mode_t o_mode;
  wire [5:0]   o;
  int          bad_count;
  int          num_checks;

  lsmdc_grabber i_fg (.i_clock(i_clock), .i_rst(i_rst), .i_level(lvl), .o_cc3(cc3));
  lsmdc_ctrl i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .i_cmd_arg(i_cmd_arg), .i_cc3(cc3), .i_line_start(i_line_start),
    .o_mode(o_mode), .o_read_bottom(o[5]), .o_read_top(o[4]), .o_sum_lines(o[3]),
    .o_tall_pixel(o[2]), .o_dir_reverse(o[1]), .o_cmd_reject(o[0]));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic send(input logic [1:0] c, input logic [1:0] a, input logic rej);
    @(posedge i_clock);
    i_cmd_valid <= 1'b1;
    i_cmd       <= lsmdc_cmd_t'(c);
    i_cmd_arg   <= a;
    @(posedge i_clock);
    i_cmd_valid <= 1'b0;
    #1;
    chk("reject", {7'h00, o[0]}, {7'h00, rej});
  endtask : send

  task automatic outs(input lsmdc_mode_t m, input logic d);
    chk("outputs", {1'b0, o_mode, o[5:1]}, {1'b0, m, 1'b1, m != LSMDC_MODE_LOW,
        m == LSMDC_MODE_HIGH, m == LSMDC_MODE_TALL, d});
  endtask : outs

  task automatic line(input lsmdc_mode_t m, input logic d);
    @(posedge i_clock);
    i_line_start <= 1'b1;
    @(posedge i_clock);
    i_line_start <= 1'b0;
    #1;
    outs(m, d);
  endtask : line

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_modes;
    lsmdc_mode_t seq [3] = '{LSMDC_MODE_LOW, LSMDC_MODE_TALL, LSMDC_MODE_HIGH};
    lsmdc_mode_t prev = LSMDC_MODE_HIGH;
    outs(LSMDC_MODE_HIGH, 1'b0);
    foreach (seq[k]) begin
      send(2'b00, 2'b01, 1'b0);
      send(2'b00, seq[k], 1'b0);
      outs(prev, 1'b0);
      line(seq[k], 1'b0);
      prev = seq[k];
    end
  endtask : t_modes

  task automatic t_reject;
    send(2'b00, 2'b10, 1'b0);
    send(2'b00, 2'b11, 1'b1);
    send(2'b11, 2'b01, 1'b1);
    line(LSMDC_MODE_TALL, 1'b0);
  endtask : t_reject

  task automatic t_dir;
    send(2'b00, 2'b00, 1'b0);
    send(2'b10, 2'b01, 1'b0);
    line(LSMDC_MODE_HIGH, 1'b1);
    send(2'b00, 2'b01, 1'b0);
    line(LSMDC_MODE_LOW, 1'b0);
    send(2'b00, 2'b00, 1'b0);
    line(LSMDC_MODE_HIGH, 1'b1);
  endtask : t_dir

  task automatic t_cc3;
    send(2'b01, 2'b01, 1'b0);
    line(LSMDC_MODE_HIGH, 1'b0);
    @(posedge i_clock);
    lvl <= 1'b1;
    repeat (4) @(posedge i_clock);
    outs(LSMDC_MODE_HIGH, 1'b0);
    line(LSMDC_MODE_HIGH, 1'b1);
    send(2'b01, 2'b00, 1'b0);
    send(2'b10, 2'b00, 1'b0);
    line(LSMDC_MODE_HIGH, 1'b0);
  endtask : t_cc3

  task automatic t_reset;
    send(2'b00, 2'b10, 1'b0);
    line(LSMDC_MODE_TALL, 1'b0);
    send(2'b00, 2'b01, 1'b0);
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    #1;
    outs(LSMDC_MODE_HIGH, 1'b0);
    chk("reject", {7'h00, o[0]}, 8'h00);
    line(LSMDC_MODE_HIGH, 1'b0);
  endtask : t_reset

  task automatic close_out;
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  initial begin
    repeat (2000) @(posedge i_clock);
    bad_count++;
    close_out();
  end

  initial begin
    i_rst        = 1'b1;
    i_cmd_valid  = 1'b0;
    i_cmd        = LSMDC_CMD_MODE;
    i_cmd_arg    = 2'b00;
    i_line_start = 1'b0;
    lvl          = 1'b0;
    bad_count    = 0;
    num_checks   = 0;
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    t_modes();
    t_reject();
    t_dir();
    t_cc3();
    t_reset();
    close_out();
  end
endmodule : tb_top
